// *** core/crsc_defines.svh ***
// Purpose: Constants for the card read-select and clear block
// Assumes: 32-bit AXI4-Lite register bus, byte addresses
// Notes: Offsets are word aligned
`ifndef CRSC_DEFINES_SVH
`define CRSC_DEFINES_SVH
`define CRSC_OFF_CMD 4'h0
`define CRSC_OFF_CTRL 4'h4
`define CRSC_OFF_RESULT 4'h8
`define CRSC_OFF_STATUS 4'hC
`define CRSC_CMD_DEV_READ 0
`define CRSC_CMD_STAT_READ 1
`define CRSC_CMD_OPERAND 31
`define CRSC_CTRL_TERM 4
`define CRSC_CTRL_LOAD 14
`define CRSC_CTRL_UNLOAD 15
`define CRSC_RESP_OKAY 2'h0
`define CRSC_RESP_SLVERR 2'h2
`endif

// *** core/crsc_pkg.sv ***
// Purpose: Types for the card read-select and clear block
// Assumes: Constants come from crsc_defines.svh
// Notes: Read path sequencing state
package crsc_pkg;
	typedef enum logic [2:0] {
		CRSC_IDLE = 3'b001,
		CRSC_SEL = 3'b010,
		CRSC_DRIVE = 3'b100
	} crsc_rd_state_type;
endpackage

// *** core/crsc_sel_if.sv ***
// Purpose: Carrier between the top and the selector bank
// Assumes: Single clock
// Notes: None
`timescale 1ns/1ns
interface crsc_sel_if;
	logic sel_status;
	logic enable;
	logic [3:0] status_inputs;
	logic [3:0] data_inputs;
	logic [3:0] result;
	modport ctrl (output sel_status, output enable, output status_inputs, output data_inputs,
		input result);
	modport mux (input sel_status, input enable, input status_inputs, input data_inputs,
		output result);
endinterface

// *** core/crsc_top.sv ***
// Purpose: Processor read select and card clear-read-buffer control
// Assumes: Reads and control words are issued by writing the command and control registers
// Notes: External result lines are driven only during a read
// How it works
// - Operand top bit picks status or peripheral data on a device-read.
// - Status-select asserts on status-read or device-read with instruction bit set.
// - With status-select, all four selectors pass their status inputs.
// - Status read raises output enable together with status-select.
// - Data read keeps status-select low; data-read strobe raises output enable.
// - Selectors output low whenever their enable is inactive.
// - Terminate bit in control word asserts clear-read-buffer low.
// - Load set with unload clear also asserts clear-read-buffer.
// - Load-buffer flag set from control word bit 14.
// - Unload-buffer flag taken from control word bit 15.
`timescale 1ns/1ns
`include "crsc_defines.svh"
module crsc_top
	import crsc_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// AXI4-Lite write address
	input wire logic [3:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// AXI4-Lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read address
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Controller status and peripheral data
	input wire logic [3:0] status_inputs,
	input wire logic [3:0] data_inputs,
	// Processor result lines
	output logic [3:0] ext_result,
	output logic ext_output_enable,
	output logic status_select,
	// Peripheral
	output logic clear_read_buffer_n
);
	crsc_sel_if sel_bus();
	crsc_rd_state_type state_q;
	logic aw_hold_q;
	logic w_hold_q;
	logic [3:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic [31:0] operand_register;
	logic load_buffer_flag;
	logic unload_buffer_flag;
	logic terminate_latch;
	logic status_instr_decode;
	logic instruction_bit_decode;
	logic data_read_strobe_n;
	logic sel_status_q;
	logic enable_q;
	logic read_pending_q;
	logic [3:0] last_result_q;
	logic wr_fire;
	logic cmd_wr;
	logic ctrl_wr;
	logic start_read;

	assign wr_fire = aw_hold_q && w_hold_q && !s_axi_bvalid;
	assign cmd_wr = wr_fire && awaddr_q == `CRSC_OFF_CMD && wstrb_q[0];
	assign ctrl_wr = wr_fire && awaddr_q == `CRSC_OFF_CTRL && wstrb_q[1] && wstrb_q[0];
	assign start_read = cmd_wr && state_q == CRSC_IDLE &&
		(wdata_q[`CRSC_CMD_DEV_READ] || wdata_q[`CRSC_CMD_STAT_READ]);
	assign status_instr_decode = wdata_q[`CRSC_CMD_STAT_READ];
	// Instruction bit is the operand's most significant bit
	assign instruction_bit_decode = wdata_q[`CRSC_CMD_DEV_READ] &&
		operand_register[`CRSC_CMD_OPERAND];
	assign data_read_strobe_n = !(wdata_q[`CRSC_CMD_DEV_READ] &&
		!operand_register[`CRSC_CMD_OPERAND] && !status_instr_decode);

	// Write address and data captured independently
	always_ff @(posedge clk) begin
		if (!resetn) begin
			aw_hold_q <= 1'b0;
			awaddr_q <= 4'h0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_hold_q <= 1'b1;
			awaddr_q <= s_axi_awaddr;
		end else if (wr_fire) begin
			aw_hold_q <= 1'b0;
		end
	end
	always_ff @(posedge clk) begin
		if (!resetn) begin
			w_hold_q <= 1'b0;
			wdata_q <= 32'h0;
			wstrb_q <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_hold_q <= 1'b1;
			wdata_q <= s_axi_wdata;
			wstrb_q <= s_axi_wstrb;
		end else if (wr_fire) begin
			w_hold_q <= 1'b0;
		end
	end
	always_ff @(posedge clk) begin
		if (!resetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
		end else begin
			s_axi_awready <= !aw_hold_q && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
			s_axi_wready <= !w_hold_q && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
		end
	end
	always_ff @(posedge clk) begin
		if (!resetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `CRSC_RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= (awaddr_q == `CRSC_OFF_CMD || awaddr_q == `CRSC_OFF_CTRL) ?
				`CRSC_RESP_OKAY : `CRSC_RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Operand register: command word with read requests kept out
	always_ff @(posedge clk) begin
		if (!resetn) begin
			operand_register <= 32'h0;
		end else if (cmd_wr && !(wdata_q[`CRSC_CMD_DEV_READ] || wdata_q[`CRSC_CMD_STAT_READ])) begin
			operand_register <= wdata_q;
		end
	end

	// Control word flags
	always_ff @(posedge clk) begin
		if (!resetn) begin
			load_buffer_flag <= 1'b0;
			unload_buffer_flag <= 1'b0;
			terminate_latch <= 1'b0;
		end else if (ctrl_wr) begin
			load_buffer_flag <= wdata_q[`CRSC_CTRL_LOAD];
			unload_buffer_flag <= wdata_q[`CRSC_CTRL_UNLOAD];
			terminate_latch <= wdata_q[`CRSC_CTRL_TERM];
		end
	end
	// Clear line follows the latched control word until the next one
	always_ff @(posedge clk) begin
		if (!resetn) begin
			clear_read_buffer_n <= 1'b1;
		end else if (ctrl_wr) begin
			clear_read_buffer_n <= !(wdata_q[`CRSC_CTRL_TERM] ||
				(wdata_q[`CRSC_CTRL_LOAD] && !wdata_q[`CRSC_CTRL_UNLOAD]));
		end
	end

	// Read sequencer: select, then drive, then release
	always_ff @(posedge clk) begin
		if (!resetn) begin
			state_q <= CRSC_IDLE;
			sel_status_q <= 1'b0;
			enable_q <= 1'b0;
		end else begin
			case (state_q)
				CRSC_IDLE: begin
					if (start_read) begin
						state_q <= CRSC_SEL;
						sel_status_q <= status_instr_decode || instruction_bit_decode;
						enable_q <= status_instr_decode || instruction_bit_decode ||
							!data_read_strobe_n;
					end
				end
				CRSC_SEL: begin
					state_q <= CRSC_DRIVE;
				end
				CRSC_DRIVE: begin
					state_q <= CRSC_IDLE;
					sel_status_q <= 1'b0;
					enable_q <= 1'b0;
				end
				default: begin
					state_q <= CRSC_IDLE;
					sel_status_q <= 1'b0;
					enable_q <= 1'b0;
				end
			endcase
		end
	end

	assign sel_bus.sel_status = sel_status_q;
	assign sel_bus.enable = enable_q;
	assign sel_bus.status_inputs = status_inputs;
	assign sel_bus.data_inputs = data_inputs;
	crsc_two_way_selector u_sel (
		.clk(clk),
		.resetn(resetn),
		.sel(sel_bus)
	);

	always_ff @(posedge clk) begin
		if (!resetn) begin
			ext_result <= 4'h0;
			ext_output_enable <= 1'b0;
			status_select <= 1'b0;
		end else begin
			// Result lines stay low outside the single drive cycle
			if (enable_q && state_q == CRSC_DRIVE) begin
				ext_result <= sel_bus.result;
			end else begin
				ext_result <= 4'h0;
			end
			ext_output_enable <= enable_q && state_q == CRSC_DRIVE;
			status_select <= sel_status_q && state_q == CRSC_DRIVE;
		end
	end
	always_ff @(posedge clk) begin
		if (!resetn) begin
			last_result_q <= 4'h0;
			read_pending_q <= 1'b0;
		end else begin
			read_pending_q <= state_q != CRSC_IDLE;
			if (state_q == CRSC_DRIVE) begin
				last_result_q <= sel_bus.result;
			end
		end
	end

	// Register reads
	always_ff @(posedge clk) begin
		if (!resetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= `CRSC_RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= `CRSC_RESP_OKAY;
				case (s_axi_araddr)
					`CRSC_OFF_CMD: s_axi_rdata <= operand_register;
					`CRSC_OFF_CTRL: s_axi_rdata <= {16'h0, unload_buffer_flag, load_buffer_flag,
						9'h0, terminate_latch, 4'h0};
					`CRSC_OFF_RESULT: s_axi_rdata <= {28'h0, last_result_q};
					`CRSC_OFF_STATUS: s_axi_rdata <= {28'h0, read_pending_q, !clear_read_buffer_n,
						status_select, ext_output_enable};
					default: begin
						s_axi_rdata <= 32'h0;
						s_axi_rresp <= `CRSC_RESP_SLVERR;
					end
				endcase
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule // crsc_top

// *** core/crsc_two_way_selector.sv ***
// Purpose: Four 2-to-1 selectors with a common select and enable
// Assumes: Enable active high inside the design
// Notes: Output registered; low whenever not enabled
`timescale 1ns/1ns
module crsc_two_way_selector
	import crsc_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Selector bundle
	crsc_sel_if.mux sel
);
	genvar i;
	generate
		for (i = 0; i < 4; i++) begin : g_bit
			always_ff @(posedge clk) begin
				if (!resetn) begin
					sel.result[i] <= 1'b0;
				end else if (!sel.enable) begin
					sel.result[i] <= 1'b0;
				end else if (sel.sel_status) begin
					sel.result[i] <= sel.status_inputs[i];
				end else begin
					sel.result[i] <= sel.data_inputs[i];
				end
			end
		end
	endgenerate
endmodule // crsc_two_way_selector

// *** dv/crsc_card_model.sv ***
// Purpose: Card peripheral and status source
// Assumes: Bench supplies status and column values
// Notes: Column lines toggle until start and again after a clear
`timescale 1ns/1ns
module crsc_card_model (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Bench control
	input wire logic start,
	input wire logic [3:0] stat_val,
	input wire logic [3:0] data_val,
	// Design side
	input wire logic clear_read_buffer_n,
	output logic [3:0] status_inputs,
	output logic [3:0] data_inputs,
	output logic [2:0] state_q
);
	assign status_inputs = stat_val;
	always_ff @(posedge clk) begin
		if (!resetn || !clear_read_buffer_n) begin
			state_q <= 3'h0;
		end else if (start) begin
			state_q <= 3'h5;
		end
	end
	always_ff @(posedge clk) begin
		if (!resetn) begin
			data_inputs <= 4'hA;
		end else begin
			data_inputs <= (state_q == 3'h5) ? data_val : ~data_inputs;
		end
	end
endmodule // crsc_card_model

// *** dv/crsc_top_sva.sv ***
// Purpose: Port checker for crsc_top
// Assumes: Read inputs held steady while a read is under way
// Notes: Bound to the design top
`timescale 1ns/1ns
module crsc_top_chk (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Bus response
	input wire logic s_axi_bvalid,
	// Selector side
	input wire logic [3:0] status_inputs,
	input wire logic [3:0] data_inputs,
	input wire logic [3:0] ext_result,
	input wire logic ext_output_enable,
	input wire logic status_select,
	input wire logic clear_read_buffer_n
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	a_oe_one_cycle: assert property (ext_output_enable |=> !ext_output_enable)
		else $error("output enable held too long");
	a_no_drive_idle: assert property (!$past(s_axi_bvalid, 2) |-> !ext_output_enable)
		else $error("output enable without a command");
	a_oe_after_cmd: assert property ($rose(ext_output_enable) |-> $past(s_axi_bvalid, 2))
		else $error("output enable at wrong time");
	a_sel_with_oe: assert property (status_select |-> ext_output_enable)
		else $error("status select without enable");
	a_status_path: assert property (status_select |-> ext_result == status_inputs)
		else $error("status bits not passed");
	a_data_path: assert property (ext_output_enable && !status_select |->
		ext_result == data_inputs)
		else $error("data bits not passed");
	a_idle_low: assert property (!ext_output_enable |-> ext_result == 4'h0)
		else $error("result lines not low");
	a_clear_on_ctrl: assert property ($changed(clear_read_buffer_n) |-> s_axi_bvalid)
		else $error("clear line moved without a control word");
	c_status: cover property (status_select);
	c_data: cover property (ext_output_enable && !status_select);
	c_clear: cover property ($fell(clear_read_buffer_n));
endmodule // crsc_top_chk
bind crsc_top crsc_top_chk crsc_top_chk_i (.clk, .resetn, .s_axi_bvalid, .status_inputs,
	.data_inputs, .ext_result, .ext_output_enable, .status_select, .clear_read_buffer_n);

// *** dv/tb_top.sv ***
// Purpose: Self-checking bench for crsc_top
// Assumes: Bus ready lines for responses held high
// Notes: Expected values worked out from the written words
`timescale 1ns/1ns
module tb_top;
	logic clk, resetn, awvalid, wvalid, bready, arvalid, rready, start;
	logic awready, wready, bvalid, arready, rvalid, oe, sel, clr_n;
	logic [3:0] awaddr, araddr, stat_val, data_val, stat_in, data_in, result;
	logic [31:0] wdata, rdata, rd_data;
	logic [1:0] bresp, rresp;
	logic [2:0] card_state;
	logic [3:0] exp_q[$];
	int failures, compares, i, n, op;
	crsc_top crsc_top_i (.clk(clk), .resetn(resetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.status_inputs(stat_in), .data_inputs(data_in), .ext_result(result),
		.ext_output_enable(oe), .status_select(sel), .clear_read_buffer_n(clr_n));
	crsc_card_model crsc_card_model_i (.clk(clk), .resetn(resetn), .start(start),
		.stat_val(stat_val), .data_val(data_val), .clear_read_buffer_n(clr_n),
		.status_inputs(stat_in), .data_inputs(data_in), .state_q(card_state));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		chk({30'h0, bresp}, (a == 4'h0 || a == 4'h4) ? 32'h0 : 32'h2);
	endtask
	task automatic rd(input logic [3:0] a);
		araddr <= a;
		arvalid <= 1'b1;
		do begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		rd_data = rdata;
		chk({30'h0, rresp}, (a > 4'hC || a[1:0] != 2'h0) ? 32'h2 : 32'h0);
	endtask
	task automatic summarize;
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	initial begin
		#60000;
		failures++;
		summarize();
	end
	initial begin
		{resetn, awvalid, wvalid, arvalid, start, awaddr, araddr, wdata} = '0;
		{bready, rready} = 2'b11;
		{stat_val, data_val} = 8'h5C;
		void'($urandom(32'h55883F10));
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		repeat (2) @(posedge clk);
		for (i = 0; i < 8; i++) begin
			start <= 1'b1;
			@(posedge clk);
			start <= 1'b0;
			wr(4'h4, {16'h0, i[2], i[1], 9'h0, i[0], 4'h0});
			@(posedge clk);
			chk({31'h0, clr_n}, {31'h0, !(i[0] || (i[1] && !i[2]))});
			if (!clr_n) chk({29'h0, card_state}, 32'h0);
			rd(4'h4);
			chk(rd_data & 32'h0000C010, {16'h0, i[2], i[1], 9'h0, i[0], 4'h0});
		end
		$display("test control words done");
		wr(4'h4, 32'h0000C000);
		start <= 1'b1;
		@(posedge clk);
		start <= 1'b0;
		for (i = 0; i < 12; i++) begin
			op = (i % 4 == 1) ? 32'h80000000 : 0;
			if (i % 4 == 1 || i % 4 == 2) wr(4'h0, op);
			stat_val <= 4'($urandom);
			data_val <= 4'($urandom);
			wr(4'h0, (i % 4 == 0) ? 32'h2 : ((i % 4 == 3) ? 32'h3 : 32'h1));
			exp_q.push_back((i % 4 != 2) ? stat_val : data_val);
			n = 0;
			while (!oe && n < 8) begin
				@(posedge clk);
				n++;
			end
			chk({31'h0, oe}, 32'h1);
			chk({31'h0, sel}, {31'h0, i % 4 != 2});
			chk({28'h0, result}, {28'h0, exp_q[0]});
			@(posedge clk);
			chk({27'h0, oe, result}, 32'h0);
			rd(4'h8);
			chk(rd_data, {28'h0, exp_q.pop_front()});
		end
		$display("test reads done");
		rd(4'h6);
		$display("test unmapped done");
		summarize();
	end
endmodule // tb_top
